// ### test/core_model.sv
// Purpose: stand-in for the cpu core retiring instructions
// Assumes: gap sets idle cycles between retired instructions
// Notes: no retirement while run is low
`timescale 1ns/1ps
module core_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pacing
  input wire logic run,
  input wire logic [1:0] gap,
  // retirement
  output logic instr_done
);
  logic [1:0] cnt;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 2'h0;
      instr_done <= 1'b0;
    end else if (run && cnt == gap) begin
      cnt <= 2'h0;
      instr_done <= 1'b1;
    end else begin
      cnt <= run ? cnt + 2'h1 : 2'h0;
      instr_done <= 1'b0;
    end
  end
endmodule

// ### test/tb.sv
// Purpose: self-checking bench for the cpu system register block
// Assumes: default stack width and top, 40 MHz clock
// Notes: inputs change 2 ns after the rising edge
`timescale 1ns/1ps
module tb;
  import cpu_sys_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic ref_clk, rst, io_wr, io_rd, io_wait, instr_done, run, waited;
  logic other_io_wr, data_mem_wr, nvm_access, sleep_exec, irq_take;
  logic irq_enable_instruction, irq_disable_instruction;
  logic bit_store_instruction, bit_store_value, irq_request;
  logic io_unlock_active, selfprog_unlock_active, bit_load_value;
  logic [7:0] io_addr, io_wdata, io_rdata, flag_load, flag_mask, q;
  logic [7:0] cpu_result_flags, key;
  logic [15:0] stack_top_pointer;
  logic [6:0] ev;
  logic [1:0] gap;
  int n_fail, tests_run;
  row_t rows [6] = '{'{OFS_FLAGS, 8'h0F, 8'h0F}, '{OFS_FLAGS, 8'h04, 8'h14},
    '{OFS_FLAGS, 8'h10, 8'h00}, '{OFS_FLAGS, 8'h6C, 8'h6C},
    '{OFS_GUARD, 8'h12, 8'h00}, '{8'h05, 8'hAA, 8'h00}};

  assign {bit_store_instruction, irq_disable_instruction,
    irq_enable_instruction, sleep_exec, nvm_access, data_mem_wr,
    other_io_wr} = ev;

  cpu_system_regs_guard cpu_system_regs_guard_i (.ref_clk, .rst, .io_addr,
    .io_wr, .io_rd, .io_wdata, .io_rdata, .io_wait, .instr_done,
    .other_io_wr, .data_mem_wr, .nvm_access, .sleep_exec, .flag_load,
    .flag_mask, .irq_enable_instruction, .irq_disable_instruction,
    .bit_store_instruction, .bit_store_value, .irq_request, .irq_take,
    .stack_top_pointer, .cpu_result_flags, .io_unlock_active,
    .selfprog_unlock_active, .bit_load_value);
  core_model core_model_i (.ref_clk, .rst, .run, .gap, .instr_done);

  always #12.5 ref_clk = ~ref_clk;

  // ***********************
  // tasks
  // ***********************
  task automatic final_report();
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    chk16({8'h00, g}, {8'h00, e});
  endtask

  task automatic chk1(input logic g, input logic e);
    chk16({15'h0000, g}, {15'h0000, e});
  endtask

  task automatic step();
    @(posedge ref_clk);
    #2;
  endtask

  // write held a second cycle when the core is told to wait
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    #1 waited = io_wait;
    step();
    if (waited) step();
    io_wr = 1'b0;
    step();
  endtask

  task automatic rd(input logic [7:0] a);
    io_addr = a;
    io_rd = 1'b1;
    step();
    io_rd = 1'b0;
    q = io_rdata;
    step();
  endtask

  task automatic pulse(input int i);
    ev[i] = 1'b1;
    step();
    ev = 7'h00;
    step();
  endtask

  // counts instructions until the chosen guard drops
  task automatic wait_n(input int s);
    int n;
    int k;
    logic act;
    n = 0;
    run = 1'b1;
    for (k = 0; k < 60; k++) begin
      step();
      act = s == 0 ? io_unlock_active : s == 1 ? selfprog_unlock_active
        : !irq_take;
      if (act !== 1'b1) break;
      if (instr_done === 1'b1) n++;
    end
    run = 1'b0;
    if (k == 60) begin
      n_fail++;
      final_report();
    end else begin
      chk16(16'(n), 16'h0004);
    end
  endtask

  // ***********************
  // sequence
  // ***********************
  initial begin
    ref_clk = 0; rst = 1; io_addr = 0; io_wdata = 0; io_wr = 0; io_rd = 0;
    ev = 0; flag_load = 0; flag_mask = 0; bit_store_value = 0;
    irq_request = 0; run = 0; gap = 0; n_fail = 0; tests_run = 0;
    repeat (3) @(posedge ref_clk);
    #2 rst = 0;
    chk16(stack_top_pointer, 16'h3FFF);
    chk8(cpu_result_flags, FLAGS_RESET);
    rd(OFS_GUARD);
    chk8(q, GUARD_RESET);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk8(q, rows[i].e);
    end
    irq_request = 1'b1;
    wr(OFS_FLAGS, 8'h80);
    chk1(waited, 1'b1);
    chk8(cpu_result_flags, 8'h80);
    chk1(irq_take, 1'b1);
    pulse(5);
    chk1(irq_take, 1'b0);
    pulse(4);
    flag_load = 8'h2B;
    flag_mask = 8'h3F;
    step();
    chk8(cpu_result_flags, 8'hBB);
    flag_load = 8'h00;
    flag_mask = 8'h01;
    step();
    flag_mask = 8'h00;
    chk8(cpu_result_flags, 8'hBA);
    bit_store_value = 1'b1;
    pulse(6);
    chk1(bit_load_value, 1'b1);
    chk8(cpu_result_flags, 8'hFA);
    // low byte first, as software must
    wr(OFS_SP_LOW, 8'h34);
    chk16(stack_top_pointer, 16'h3FFF);
    chk1(irq_take, 1'b0);
    wr(OFS_SP_HIGH, 8'hD2);
    chk16(stack_top_pointer, 16'h1234);
    chk1(irq_take, 1'b1);
    irq_request = 1'b0;
    rd(OFS_SP_LOW);
    chk8(q, 8'h34);
    rd(OFS_SP_HIGH);
    chk8(q, 8'h12);
    irq_request = 1'b1;
    wr(OFS_SP_LOW, 8'h56);
    rd(OFS_SP_HIGH);
    chk8(q, 8'h56);
    chk16(stack_top_pointer, 16'h1234);
    gap = 2'h2;
    wait_n(2);
    wr(OFS_GUARD, IO_UNLOCK_KEY);
    chk1(irq_take, 1'b0);
    rd(OFS_GUARD);
    chk8(q, 8'h01);
    gap = 2'h0;
    wait_n(0);
    chk1(irq_take, 1'b1);
    wr(OFS_GUARD, SELFPROG_UNLOCK_KEY);
    rd(OFS_GUARD);
    chk8(q, 8'h02);
    gap = 2'h1;
    wait_n(1);
    for (int i = 0; i < 8; i++) begin
      key = i < 4 ? IO_UNLOCK_KEY : SELFPROG_UNLOCK_KEY;
      wr(OFS_GUARD, key);
      pulse(i % 4);
      q[0] = io_unlock_active | selfprog_unlock_active;
      chk1(q[0], i == 4 || i == 5);
      pulse(3);
    end
    // paired bytes on consecutive cycles
    io_addr = OFS_SP_LOW;
    io_wdata = 8'h78;
    io_wr = 1'b1;
    step();
    io_addr = OFS_SP_HIGH;
    io_wdata = 8'h00;
    step();
    io_wr = 1'b0;
    step();
    chk16(stack_top_pointer, 16'h0078);
    rst = 1'b1;
    step();
    chk16(stack_top_pointer, 16'h3FFF);
    chk8(cpu_result_flags, FLAGS_RESET);
    chk1(irq_take, 1'b0);
    rst = 1'b0;
    step();
    final_report();
  end
endmodule

// ### verilog/cpu_sys_pkg.sv
// Purpose: constants for the cpu system register block
// Assumes: 8-bit i/o bus, offsets are byte addresses of the cpu window
// Notes: none
package cpu_sys_pkg;
  // ***********************
  // offsets
  // ***********************
  localparam logic [7:0] OFS_GUARD = 8'h04;
  localparam logic [7:0] OFS_SP_LOW = 8'h0D;
  localparam logic [7:0] OFS_SP_HIGH = 8'h0E;
  localparam logic [7:0] OFS_FLAGS = 8'h0F;
  // ***********************
  // keys and reset values
  // ***********************
  localparam logic [7:0] IO_UNLOCK_KEY = 8'hD8;
  localparam logic [7:0] SELFPROG_UNLOCK_KEY = 8'h9D;
  localparam logic [7:0] GUARD_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [2:0] GUARD_WINDOW_INSTR = 3'h4;
  localparam logic [2:0] SP_HOLD_INSTR = 3'h4;
  // ***********************
  // flag positions
  // ***********************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam int GUARD_IO_BIT = 0;
  localparam int GUARD_SELFPROG_BIT = 1;
endpackage

// ### verilog/cpu_system_regs_guard.sv
// Purpose: cpu system registers, 16-bit staging, change guard, flags
// Assumes: core pulses io_rd/io_wr per access and instr_done per instruction
// Notes: alu flags arrive on flag_load with flag_mask per bit
`timescale 1ns/1ps
// Behaviour
// - low byte write goes to staging latch
// - high byte write commits staging plus high
// - low byte read captures high into latch
// - high byte read returns the latch
// - key D8 opens io unlock, four instructions
// - key 9D opens selfprog unlock, four instructions
// - io unlock closes on writes, nvm, sleep
// - selfprog unlock closes on nvm, sleep
// - no interrupt taken while unlock open
// - key reads bit0 io, bit1 selfprog
// - stack pointer resets to sram top
// - unimplemented stack bits read zero on stack_top_pointer and in a high byte read after a low byte read
// - stack low write blocks interrupts briefly
// - flag bit 7 is global interrupt enable
// - only software changes interrupt enable
// - enable change via io adds wait
// - sign equals negative xor overflow
// - alu flags set or cleared per operation
// - bit 6 serves bit load and store
// - flags not saved on interrupt entry
module cpu_system_regs_guard
  import cpu_sys_pkg::*;
#(
  parameter int SP_ADDR_BITS = 14,
  parameter logic [15:0] SRAM_TOP = 16'h3FFF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // internal i/o bus
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_wait,
  // core events
  input wire logic instr_done,
  input wire logic other_io_wr,
  input wire logic data_mem_wr,
  input wire logic nvm_access,
  input wire logic sleep_exec,
  // flag updates from the core
  input wire logic [7:0] flag_load,
  input wire logic [7:0] flag_mask,
  input wire logic irq_enable_instruction,
  input wire logic irq_disable_instruction,
  input wire logic bit_store_instruction,
  input wire logic bit_store_value,
  // interrupt side
  input wire logic irq_request,
  output logic irq_take,
  // state out
  output logic [15:0] stack_top_pointer,
  output logic [7:0] cpu_result_flags,
  output logic io_unlock_active,
  output logic selfprog_unlock_active,
  output logic bit_load_value
);
  default clocking ck @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ***********************
  // decode
  // ***********************
  logic [7:0] staging;
  logic [7:0] flags;
  logic [2:0] sp_hold;
  logic wait_done;
  logic [15:0] sp_value;
  wire sel_guard = (io_addr == OFS_GUARD);
  wire sel_sp_low = (io_addr == OFS_SP_LOW);
  wire sel_sp_high = (io_addr == OFS_SP_HIGH);
  wire sel_flags = (io_addr == OFS_FLAGS);
  wire wr_guard = io_wr && sel_guard;
  wire wr_sp_low = io_wr && sel_sp_low;
  wire wr_sp_high = io_wr && sel_sp_high;
  wire rd_sp_low = io_rd && sel_sp_low;
  wire ie_change = io_wr && sel_flags && (io_wdata[FLAG_I] != flags[FLAG_I]);
  wire flags_wr = io_wr && sel_flags && !io_wait;
  wire any_io_wr = io_wr || other_io_wr;

  // ***********************
  // unlock windows
  // ***********************
  window_if io_win ();
  window_if sp_win ();
  assign io_win.open_req = wr_guard && io_wdata == IO_UNLOCK_KEY;
  assign io_win.close_req = any_io_wr || data_mem_wr || nvm_access ||
    sleep_exec;
  assign io_win.instr_done = instr_done;
  assign sp_win.open_req = wr_guard && io_wdata == SELFPROG_UNLOCK_KEY;
  assign sp_win.close_req = nvm_access || sleep_exec;
  assign sp_win.instr_done = instr_done;

  instr_window #(.LENGTH(GUARD_WINDOW_INSTR)) io_window (
    .ref_clk(ref_clk),
    .rst(rst),
    .win(io_win)
  );
  instr_window #(.LENGTH(GUARD_WINDOW_INSTR)) selfprog_window (
    .ref_clk(ref_clk),
    .rst(rst),
    .win(sp_win)
  );
  assign io_unlock_active = io_win.active;
  assign selfprog_unlock_active = sp_win.active;

  // ***********************
  // stack pointer and staging
  // ***********************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      staging <= 8'h00;
    end else if (wr_sp_low) begin
      staging <= io_wdata;
    end else if (rd_sp_low) begin
      staging <= sp_value[15:8];
    end
  end

  stack_reg #(.ADDR_BITS(SP_ADDR_BITS), .TOP(SRAM_TOP)) stack (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(wr_sp_high),
    .load_value({io_wdata, staging}),
    .value(sp_value)
  );
  assign stack_top_pointer = sp_value;

  // stack low write holds off interrupts
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sp_hold <= 3'h0;
    end else if (wr_sp_low) begin
      sp_hold <= SP_HOLD_INSTR;
    end else if (any_io_wr) begin
      sp_hold <= 3'h0;
    end else if (instr_done && sp_hold != 3'h0) begin
      sp_hold <= sp_hold - 3'h1;
    end
  end

  // ***********************
  // flags
  // ***********************
  // enable change through i/o stalls one cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_done <= 1'b0;
    end else begin
      wait_done <= ie_change && !wait_done;
    end
  end
  assign io_wait = ie_change && !wait_done;

  logic [7:0] next_flags;
  always_comb begin
    next_flags = flags;
    if (flags_wr) begin
      next_flags = io_wdata;
    end else begin
      next_flags[5:0] = (flags[5:0] & ~flag_mask[5:0]) |
        (flag_load[5:0] & flag_mask[5:0]);
      if (irq_enable_instruction) begin
        next_flags[FLAG_I] = 1'b1;
      end else if (irq_disable_instruction) begin
        next_flags[FLAG_I] = 1'b0;
      end
      if (bit_store_instruction) begin
        next_flags[FLAG_T] = bit_store_value;
      end
    end
    next_flags[FLAG_S] = next_flags[FLAG_N] ^ next_flags[FLAG_V];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end
  assign cpu_result_flags = flags;
  assign bit_load_value = flags[FLAG_T];

  // ***********************
  // interrupt gate
  // ***********************
  assign irq_take = irq_request && flags[FLAG_I] &&
    !io_win.active && !sp_win.active && sp_hold == 3'h0;

  // ***********************
  // read data
  // ***********************
  logic [7:0] next_rdata;
  assign next_rdata = sel_guard ?
      {6'h00, sp_win.active, io_win.active} :
    sel_sp_low ? sp_value[7:0] :
    sel_sp_high ? staging :
    sel_flags ? flags : 8'h00;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      io_rdata <= next_rdata;
    end
  end

  // ***********************
  // checks
  // ***********************
  sequence low_write_s;
    wr_sp_low;
  endsequence
  sequence high_write_s;
    wr_sp_high && !wr_sp_low;
  endsequence
  sequence stage_idle_s;
    !wr_sp_low && !rd_sp_low;
  endsequence

  AST_STAGE_WRITE: assert property (low_write_s ##1 high_write_s |=>
    sp_value[7:0] == $past(io_wdata, 2))
    else $error("low byte not committed from staging");
  AST_STAGE_GAP: assert property (low_write_s ##1 stage_idle_s ##1
    high_write_s |=> sp_value[7:0] == $past(io_wdata, 3))
    else $error("staged low byte lost before commit");
  AST_SP_COMMIT_HIGH: assert property (high_write_s |=>
    sp_value[SP_ADDR_BITS-1:8] == $past(io_wdata[SP_ADDR_BITS-9:0]))
    else $error("high byte not committed");
  AST_LOW_HOLD: assert property ((wr_sp_low && !wr_sp_high) |=>
    $stable(sp_value))
    else $error("low byte write changed stack pointer");
  AST_READ_CAPTURE: assert property ((rd_sp_low && !wr_sp_low) |=>
    staging == $past(sp_value[15:8]))
    else $error("high byte not captured on low read");
  AST_HIGH_READ: assert property ((io_rd && sel_sp_high) |=>
    io_rdata == $past(staging))
    else $error("high byte read did not return staging");
  AST_IO_KEY: assert property (io_win.open_req |=> io_unlock_active)
    else $error("io key did not unlock");
  AST_SP_KEY: assert property (sp_win.open_req |=>
    selfprog_unlock_active)
    else $error("selfprog key did not unlock");
  AST_IO_CLOSE: assert property ((sleep_exec && !io_win.open_req) |=>
    !io_unlock_active)
    else $error("io unlock survived sleep");
  AST_IO_WR_CLOSE: assert property ((other_io_wr &&
    !io_win.open_req) |=> !io_unlock_active)
    else $error("io unlock survived i/o write");
  AST_SP_CLOSE: assert property ((nvm_access && !sp_win.open_req) |=>
    !selfprog_unlock_active)
    else $error("selfprog unlock survived nvm access");
  AST_SP_SLEEP_CLOSE: assert property ((sleep_exec &&
    !sp_win.open_req) |=> !selfprog_unlock_active)
    else $error("selfprog unlock survived sleep");
  AST_NO_IRQ: assert property ((io_unlock_active ||
    selfprog_unlock_active) |-> !irq_take)
    else $error("interrupt taken in unlock window");
  AST_KEY_READ: assert property ((io_rd && sel_guard) |=>
    io_rdata[7:2] == 6'h00 && io_rdata[0] == $past(io_unlock_active))
    else $error("key register read wrong");
  AST_KEY_READ_SP: assert property ((io_rd && sel_guard) |=>
    io_rdata[1] == $past(selfprog_unlock_active))
    else $error("key register selfprog bit wrong");
  AST_SP_BLOCK: assert property (wr_sp_low |=> !irq_take)
    else $error("interrupt taken after stack low write");
  AST_SP_HOLD_SET: assert property (wr_sp_low |=>
    sp_hold == SP_HOLD_INSTR)
    else $error("stack hold not loaded");
  AST_SP_HOLD_CLEAR: assert property ((any_io_wr && !wr_sp_low) |=>
    sp_hold == 3'h0)
    else $error("stack hold survived i/o write");
  AST_HOLD_IRQ: assert property ((sp_hold != 3'h0) |-> !irq_take)
    else $error("interrupt taken during stack hold");
  AST_IE_GATE: assert property (!flags[FLAG_I] |-> !irq_take)
    else $error("interrupt taken while disabled");
  AST_IRQ_PASS: assert property ((irq_request && flags[FLAG_I] &&
    !io_unlock_active && !selfprog_unlock_active && sp_hold == 3'h0) |->
    irq_take)
    else $error("enabled interrupt not taken");
  AST_IE_COMMIT: assert property (flags_wr |=>
    flags[FLAG_I] == $past(io_wdata[FLAG_I]))
    else $error("enable bit not written");
  AST_IE_STICKY: assert property ((!flags_wr &&
    !irq_enable_instruction && !irq_disable_instruction) |=>
    $stable(flags[FLAG_I]))
    else $error("enable changed without software");
  AST_IE_WAIT: assert property ((ie_change && !wait_done) |->
    io_wait ##1 !io_wait)
    else $error("enable change wait state wrong");
  AST_SIGN: assert property (flags[FLAG_S] ==
    (flags[FLAG_N] ^ flags[FLAG_V]))
    else $error("sign flag mismatch");
  AST_ALU_CARRY: assert property ((!flags_wr && flag_mask[FLAG_C]) |=>
    flags[FLAG_C] == $past(flag_load[FLAG_C]))
    else $error("carry not taken from alu");
  AST_BIT_STORE: assert property ((bit_store_instruction &&
    !flags_wr) |=> bit_load_value == $past(bit_store_value))
    else $error("bit store not held in flags");
endmodule

// ### verilog/instr_window.sv
// Purpose: open window lasting a set number of executed instructions
// Assumes: instr_done pulses once per retired instruction
// Notes: close and open in same cycle, open wins
`timescale 1ns/1ps
module instr_window
  import cpu_sys_pkg::*;
#(
  parameter logic [2:0] LENGTH = 3'h4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  window_if.counter win
);
  logic [2:0] left;
  logic [2:0] next_left;

  assign next_left = win.open_req ? LENGTH :
    (win.close_req ? 3'h0 :
    ((win.instr_done && left != 3'h0) ? left - 3'h1 : left));
  assign win.active = (left != 3'h0);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      left <= 3'h0;
    end else begin
      left <= next_left;
    end
  end

  default clocking ck @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  AST_WIN_CLOSE: assert property ((win.close_req &&
    !win.open_req) |=> !win.active)
    else $error("window stayed open after close");
  AST_WIN_OPEN: assert property (win.open_req |=> left == LENGTH)
    else $error("window not loaded on open");
endmodule

// ### verilog/stack_reg.sv
// Purpose: 16-bit stack pointer storage with trimmed width
// Assumes: writes come already paired by the staging latch
// Notes: unimplemented upper bits read zero
`timescale 1ns/1ps
module stack_reg
  import cpu_sys_pkg::*;
#(
  parameter int ADDR_BITS = 14,
  parameter logic [15:0] TOP = 16'h3FFF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // update
  input wire logic load,
  input wire logic [15:0] load_value,
  // state
  output logic [15:0] value
);
  logic [ADDR_BITS-1:0] bits;
  localparam logic [ADDR_BITS-1:0] TOP_TRIM = TOP[ADDR_BITS-1:0];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bits <= TOP_TRIM;
    end else if (load) begin
      bits <= load_value[ADDR_BITS-1:0];
    end
  end

  assign value = {{(16-ADDR_BITS){1'b0}}, bits};

  default clocking ck @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  AST_SP_UPPER_ZERO: assert property (value[15:ADDR_BITS] == '0)
    else $error("unimplemented stack bits not zero");
endmodule

// ### verilog/window_if.sv
// Purpose: link between the top and the unlock window counters
// Assumes: one counter instance per window
// Notes: none
`timescale 1ns/1ps
interface window_if;
  logic open_req;
  logic close_req;
  logic instr_done;
  logic active;
  modport counter (input open_req, input close_req, input instr_done,
    output active);
  modport user (output open_req, output close_req, output instr_done,
    input active);
endinterface
